// ==== verilog/two_wire_slave_address_ack.sv ====
// Two-wire slave front end: START/STOP, address match, acknowledge, data.
// Assumes a master on the far side; SCL is sampled, never driven.
//
// Contract
// - Idle lines released, rest high
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Nine-clock segments: byte plus acknowledge
// - First byte: address plus direction bit
// - Master clocks acknowledge; transmitter releases SDA
// - Slave acknowledge held low through SCL high
// - Unmatched address leaves SDA high
// - Full slave refuses next byte, master stops
// - Master reader NACKs last byte, then STOP
// - Slave drives read bits, releases for acknowledge
// - No clock stretching; SCL input only
// - Address is 11 then converter code
// - Open-drain lines, pull low only
// - Respond only to own address until START
// - No limit on bytes per transfer
// - Master keeps SCL within mode limit
// - Acknowledge only on full address match
// - Connection sense low: ignore bus, reset
`timescale 1ns/1ns
`default_nettype none

`include "tw_map.svh"

module two_wire_slave_address_ack (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst_n, // Async reset, active low
	two_wire_if.device bus, // Two-wire bus
	input wire logic i_connection_sense_input, // Pin: low disables link
	input wire logic [4:0] i_addr_code, // Converter code, address low bits
	input wire tw_pkg::tw_byte_type i_rd_data, // Byte to return on reads
	input wire logic i_accept, // 1 = can take a written byte
	output var tw_pkg::tw_byte_type o_wr_data, // Last byte written
	output logic o_wr_valid, // Pulse: o_wr_data new
	output logic o_rd_take, // Pulse: i_rd_data loaded
	output logic o_start, // Pulse: START seen
	output logic o_stop, // Pulse: STOP seen
	output logic o_selected, // Addressed and in transfer
	output logic o_rw // Direction of current transfer
);
	import tw_pkg::*;

	slave_state_type state_r;
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [1:0] connection_sense_input_q;
	logic [4:0] code_q1;
	logic [4:0] code_q2;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic rw_r;
	logic mack_r;
	logic sda_oe_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic bus_ok;
	logic wr_done;
	logic rd_load;

	function automatic logic addr_match(input logic [6:0] addr, input logic [4:0] code);
		addr_match = (addr[6:5] == `TW_ADDR_FIXED) && (addr[4:0] == code);
	endfunction : addr_match

	// Only SDA is driven, and only low; SCL has no driver here
	assign bus.sda_s_out = 1'b0;
	assign bus.sda_s_oe = sda_oe_r;

	// Stage 0 of each synchroniser feeds only stage 1
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			connection_sense_input_q <= 2'h0;
		end else begin
			scl_q <= {scl_q[1:0], bus.scl};
			sda_q <= {sda_q[1:0], bus.sda};
			connection_sense_input_q <= {connection_sense_input_q[0], i_connection_sense_input};
		end
	end

	// The code is a static strap; a brief mixed value is masked by START timing
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			code_q1 <= 5'h00;
			code_q2 <= 5'h00;
		end else begin
			code_q1 <= i_addr_code;
			code_q2 <= code_q1;
		end
	end

	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
	assign bus_ok = connection_sense_input_q[1] & ~start_det & ~stop_det;
	assign wr_done = bus_ok & (state_r == SL_WRITE) & scl_fall & (cnt_r == `TW_BIT_ACK) & i_accept;
	assign rd_load = bus_ok & scl_fall & (((state_r == SL_ACK) & rw_r) | ((state_r == SL_MACK) & mack_r));
	assign o_selected = (state_r == SL_ACK) | (state_r == SL_WRITE) | (state_r == SL_READ)
		| (state_r == SL_MACK);
	assign o_rw = rw_r;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= SL_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h0;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (!connection_sense_input_q[1]) begin
			state_r <= SL_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h0;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (start_det) begin
			// A repeated START also lands here and restarts address reception
			state_r <= SL_ADDR;
			cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else if (stop_det) begin
			state_r <= SL_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				SL_IDLE: begin
					sda_oe_r <= 1'b0;
				end
				SL_ADDR: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_q[1]};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `TW_BIT_ACK) begin
						cnt_r <= 4'h0;
						rw_r <= sh_r[0];
						if (addr_match(sh_r[7:1], code_q2)) begin
							sda_oe_r <= 1'b1;
							state_r <= SL_ACK;
						end else begin
							state_r <= SL_IGNORE;
						end
					end
				end
				SL_ACK: begin
					// Held low from the fall before the ninth clock until the fall after it
					if (scl_fall) begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							sh_r <= i_rd_data;
							sda_oe_r <= ~i_rd_data[7];
							state_r <= SL_READ;
						end else begin
							sda_oe_r <= 1'b0;
							state_r <= SL_WRITE;
						end
					end
				end
				SL_WRITE: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_q[1]};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `TW_BIT_ACK) begin
						cnt_r <= 4'h0;
						if (i_accept) begin
							sda_oe_r <= 1'b1;
							state_r <= SL_ACK;
						end else begin
							state_r <= SL_IGNORE;
						end
					end
				end
				SL_READ: begin
					if (scl_fall) begin
						if (cnt_r == `TW_BIT_LAST) begin
							cnt_r <= 4'h0;
							sda_oe_r <= 1'b0;
							state_r <= SL_MACK;
						end else begin
							sh_r <= {sh_r[6:0], 1'b0};
							sda_oe_r <= ~sh_r[6];
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				SL_MACK: begin
					if (scl_rise) begin
						mack_r <= ~sda_q[1];
					end else if (scl_fall) begin
						if (mack_r) begin
							sh_r <= i_rd_data;
							sda_oe_r <= ~i_rd_data[7];
							state_r <= SL_READ;
						end else begin
							state_r <= SL_IGNORE;
						end
					end
				end
				SL_IGNORE: begin
					sda_oe_r <= 1'b0;
				end
				default: begin
					state_r <= SL_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// User-side strobes and captured data
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wr_data <= 8'h0;
			o_wr_valid <= 1'b0;
			o_rd_take <= 1'b0;
			o_start <= 1'b0;
			o_stop <= 1'b0;
		end else begin
			o_wr_valid <= wr_done;
			o_rd_take <= rd_load;
			o_start <= connection_sense_input_q[1] & start_det;
			o_stop <= connection_sense_input_q[1] & stop_det;
			if (wr_done) begin
				o_wr_data <= sh_r;
			end
		end
	end

endmodule : two_wire_slave_address_ack

`default_nettype wire

// ==== verilog/tw_map.svh ====
// Constants shared by both ends of the two-wire link.
// Assumes a single 50 MHz system clock on each end.
`ifndef TW_MAP_SVH
`define TW_MAP_SVH

`define TW_SYS_CLK_HZ 50000000
`define TW_SCL_STD_HZ 100000
`define TW_SCL_FAST_HZ 400000
// Quarter of an SCL period in system cycles, rounded up so SCL never runs fast
`define TW_SCL_QTR_CYC ((`TW_SYS_CLK_HZ + 4 * `TW_SCL_STD_HZ - 1) / (4 * `TW_SCL_STD_HZ))
`define TW_ADDR_FIXED 2'h3
`define TW_BIT_LAST 4'h7
`define TW_BIT_ACK 4'h8

`endif

// ==== verilog/tw_pkg.sv ====
// Types shared by both ends of the two-wire link.
// Assumes tw_map.svh is compiled alongside.
package tw_pkg;

	typedef logic [7:0] tw_byte_type;

	typedef enum logic [6:0] {
		SL_IDLE = 7'h01,
		SL_ADDR = 7'h02,
		SL_ACK = 7'h04,
		SL_WRITE = 7'h08,
		SL_READ = 7'h10,
		SL_MACK = 7'h20,
		SL_IGNORE = 7'h40
	} slave_state_type;

	typedef enum logic [3:0] {
		MS_IDLE = 4'h1,
		MS_START = 4'h2,
		MS_BIT = 4'h4,
		MS_STOP = 4'h8
	} master_state_type;

endpackage : tw_pkg

// ==== verilog/two_wire_if.sv ====
// Open-drain two-wire bus joining the backplane master and the slave.
// SDA is out/oe per party, SCL out/oe for the master only; the wire level is resolved here as wired-AND.
`timescale 1ns/1ns
`default_nettype none

interface two_wire_if;
	logic scl_m_out;
	logic scl_m_oe;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// Lines rest high unless some party pulls low
	assign scl = ~(scl_m_oe & ~scl_m_out);
	assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));

	modport device (input scl, input sda, output sda_s_out, output sda_s_oe);
	modport master (input scl, input sda, output scl_m_out, output scl_m_oe,
		output sda_m_out, output sda_m_oe);
endinterface : two_wire_if

`default_nettype wire

// ==== verilog/two_wire_master_end.sv ====
// Backplane bus master end: generates START, bytes, acknowledges and STOP.
// Assumes the slave never stretches SCL and the bus has pull-ups.
`timescale 1ns/1ns
`default_nettype none

`include "tw_map.svh"

module two_wire_master_end #(
	parameter int QTR_CYC = `TW_SCL_QTR_CYC
) (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst_n, // Async reset, active low
	two_wire_if.master bus, // Two-wire bus
	input wire logic i_go, // Pulse: start a transfer
	input wire logic [6:0] i_addr, // Target address
	input wire logic i_rw, // 1 = read
	input wire logic [7:0] i_len, // Data bytes to move
	input wire tw_pkg::tw_byte_type i_wr_data, // Next byte to write
	output logic o_wr_take, // Pulse: i_wr_data taken
	output var tw_pkg::tw_byte_type o_rd_data, // Last byte read
	output logic o_rd_valid, // Pulse: o_rd_data new
	output logic o_done, // Pulse: STOP finished
	output logic o_nack, // Slave refused a byte
	output logic o_busy // Transfer running
);
	import tw_pkg::*;

	master_state_type state_r;
	logic [1:0] sda_q;
	logic [15:0] qcnt_r;
	logic tick;
	logic [1:0] q_r;
	logic [3:0] idx_r;
	logic [7:0] sh_r;
	logic [7:0] rem_r;
	logic [7:0] rem_left;
	logic tx_r;
	logic addr_f_r;
	logic rw_r;
	logic ack_ok_r;
	logic scl_oe_r;
	logic sda_oe_r;

	// Open-drain: only ever pull low
	assign bus.scl_m_out = 1'b0;
	assign bus.sda_m_out = 1'b0;
	assign bus.scl_m_oe = scl_oe_r;
	assign bus.sda_m_oe = sda_oe_r;
	assign o_busy = (state_r != MS_IDLE);
	assign tick = (qcnt_r == 16'(QTR_CYC - 1));
	assign rem_left = addr_f_r ? rem_r : rem_r - 8'h01;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sda_q <= 2'h0;
		end else begin
			sda_q <= {sda_q[0], bus.sda};
		end
	end

	// Quarter-period timebase; the default QTR_CYC keeps SCL at or below the standard rate
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcnt_r <= 16'h0;
		end else if (state_r == MS_IDLE || tick) begin
			qcnt_r <= 16'h0;
		end else begin
			qcnt_r <= qcnt_r + 16'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= MS_IDLE;
			q_r <= 2'h0;
			idx_r <= 4'h0;
			sh_r <= 8'h0;
			rem_r <= 8'h0;
			tx_r <= 1'b0;
			addr_f_r <= 1'b0;
			rw_r <= 1'b0;
			ack_ok_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			o_rd_data <= 8'h0;
			o_rd_valid <= 1'b0;
			o_wr_take <= 1'b0;
			o_done <= 1'b0;
			o_nack <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			o_wr_take <= 1'b0;
			o_done <= 1'b0;
			case (state_r)
				MS_IDLE: begin
					if (i_go) begin
						sh_r <= {i_addr, i_rw};
						rw_r <= i_rw;
						rem_r <= i_len;
						tx_r <= 1'b1;
						addr_f_r <= 1'b1;
						o_nack <= 1'b0;
						q_r <= 2'h0;
						state_r <= MS_START;
					end
				end
				MS_START: begin
					if (tick) begin
						if (q_r == 2'h0) begin
							sda_oe_r <= 1'b1;
							q_r <= 2'h1;
						end else begin
							scl_oe_r <= 1'b1;
							q_r <= 2'h0;
							idx_r <= 4'h0;
							state_r <= MS_BIT;
						end
					end
				end
				MS_BIT: begin
					if (tick) begin
						case (q_r)
							2'h0: begin
								// Data changes only while SCL is low
								if (idx_r == `TW_BIT_ACK) begin
									sda_oe_r <= tx_r ? 1'b0 : (rem_r != 8'h01);
								end else begin
									sda_oe_r <= tx_r ? ~sh_r[7] : 1'b0;
								end
								q_r <= 2'h1;
							end
							2'h1: begin
								scl_oe_r <= 1'b0;
								q_r <= 2'h2;
							end
							2'h2: begin
								if (idx_r == `TW_BIT_ACK) begin
									ack_ok_r <= ~sda_q[1];
								end else if (!tx_r) begin
									sh_r <= {sh_r[6:0], sda_q[1]};
								end
								q_r <= 2'h3;
							end
							default: begin
								scl_oe_r <= 1'b1;
								q_r <= 2'h0;
								if (idx_r != `TW_BIT_ACK) begin
									idx_r <= idx_r + 4'h1;
									if (tx_r) begin
										sh_r <= {sh_r[6:0], 1'b0};
									end
								end else begin
									idx_r <= 4'h0;
									addr_f_r <= 1'b0;
									rem_r <= rem_left;
									if (tx_r && !ack_ok_r) begin
										o_nack <= 1'b1;
										state_r <= MS_STOP;
									end else begin
										if (!tx_r) begin
											o_rd_data <= sh_r;
											o_rd_valid <= 1'b1;
										end
										if (rem_left == 8'h00) begin
											state_r <= MS_STOP;
										end else begin
											tx_r <= ~rw_r;
											if (!rw_r) begin
												sh_r <= i_wr_data;
												o_wr_take <= 1'b1;
											end
										end
									end
								end
							end
						endcase
					end
				end
				MS_STOP: begin
					if (tick) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							default: begin
								o_done <= 1'b1;
								state_r <= MS_IDLE;
							end
						endcase
					end
				end
				default: state_r <= MS_IDLE;
			endcase
		end
	end

endmodule : two_wire_master_end

`default_nettype wire

// ==== testbench/two_wire_link_chk.sv ====
// Wire checker for the two-wire link between master end and slave.
// Assumes plain hookup to the bench's interface, one system clock.
`timescale 1ns/1ns
`default_nettype none

module two_wire_link_chk (
	input wire logic i_sys_clk, // Clock
	input wire logic i_rst_n, // Reset
	input wire logic scl_m_out, // Master SCL
	input wire logic scl_m_oe, // Master SCL enable
	input wire logic sda_m_out, // Master SDA
	input wire logic sda_m_oe, // Master SDA enable
	input wire logic sda_s_out, // Slave SDA
	input wire logic sda_s_oe, // Slave SDA enable
	input wire logic scl, // Wire SCL
	input wire logic sda // Wire SDA
);
	logic scl_q_r;
	logic sda_q_r;
	logic idle_r;
	logic first_r;
	logic rw_r;
	logic [3:0] cnt_r;
	logic rise;
	logic start;
	logic stop;

	assign rise = scl & ~scl_q_r;
	assign start = scl & scl_q_r & sda_q_r & ~sda;
	assign stop = scl & scl_q_r & ~sda_q_r & sda;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl;
			sda_q_r <= sda;
		end
	end

	// Idle from STOP to START: the slave has no business on SDA there
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			idle_r <= 1'b1;
		else if (start | stop)
			idle_r <= stop;
	end

	// Position in the nine-clock segment; the first one carries the address
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 4'h0;
			first_r <= 1'b1;
			rw_r <= 1'b0;
		end else if (start) begin
			cnt_r <= 4'h0;
			first_r <= 1'b1;
		end else if (rise) begin
			cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
			if (cnt_r == 4'h8)
				first_r <= 1'b0;
			if (first_r && cnt_r == 4'h7)
				rw_r <= sda;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	drive_low_a: assert property (
		(sda_s_oe |-> !sda_s_out) and (scl_m_oe |-> !scl_m_out) and (sda_m_oe |-> !sda_m_out))
		else $error("A driver pushes a line high");
	clock_owner_a: assert property (!scl |-> scl_m_oe)
		else $error("SCL low without the master");
	scl_high_a: assert property ($rose(scl) |-> scl [*8])
		else $error("SCL high phase too short");
	idle_quiet_a: assert property (idle_r |-> !sda_s_oe)
		else $error("Slave drives SDA on an idle bus");
	slave_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("Slave moved SDA while SCL high");
	ack_hold_a: assert property ($rose(scl) && sda_s_oe |-> (sda_s_oe && !sda) [*8])
		else $error("Slave low level not held over SCL high");
	addr_listen_a: assert property (rise && first_r && cnt_r < 4'h8 |-> !sda_s_oe)
		else $error("Slave drives during the address bits");
	write_listen_a: assert property (rise && !first_r && !rw_r && cnt_r < 4'h8 |-> !sda_s_oe)
		else $error("Slave drives during written bits");
	read_release_a: assert property (rise && !first_r && rw_r && cnt_r == 4'h8 |-> !sda_s_oe)
		else $error("Slave holds SDA in the master slot");
	mack_free_a: assert property (rise && (first_r || !rw_r) && cnt_r == 4'h8 |-> !sda_m_oe)
		else $error("Master transmitter holds SDA in the acknowledge slot");

	cover property (rise && first_r && cnt_r == 4'h8 && !sda);
	cover property (rise && first_r && cnt_r == 4'h8 && sda);
	cover property (rise && !first_r && rw_r && cnt_r < 4'h8 && sda_s_oe);
	cover property (stop);
endmodule : two_wire_link_chk

`default_nettype wire

// ==== testbench/two_wire_slave_address_ack_bench.sv ====
// Bench: the master end talks to the slave over the shared interface.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module two_wire_slave_address_ack_bench;
	import tw_pkg::*;
	logic i_sys_clk, i_rst_n, go, m_rw, sense, accept, ack_exp, pscl, psda, first;
	logic [6:0] m_addr;
	logic [7:0] m_len, ab_exp, sh;
	logic [4:0] code;
	tw_byte_type m_wr_data, m_rd_data, s_rd_data, s_wr_data;
	logic m_wr_take, m_rd_valid, m_done, m_nack, s_wr_valid, s_rd_take;
	logic s_start, s_stop, s_selected, s_rw, m_busy;
	logic [7:0] wdat [8];
	logic [7:0] rdat [8];
	logic [7:0] wr_q [$];
	logic [7:0] rd_q [$];
	logic done_q [$];
	int failures, checks, wi, ri, wv, acc_n, st_n, sp_n, sel_n, bit_n;

	two_wire_if two_wire_if_i ();
	wire scl_w = two_wire_if_i.scl;
	wire sda_w = two_wire_if_i.sda;
	two_wire_master_end #(.QTR_CYC(5)) two_wire_master_end_i (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .bus(two_wire_if_i.master), .i_go(go), .i_addr(m_addr),
		.i_rw(m_rw), .i_len(m_len), .i_wr_data(m_wr_data), .o_wr_take(m_wr_take),
		.o_rd_data(m_rd_data), .o_rd_valid(m_rd_valid), .o_done(m_done), .o_nack(m_nack),
		.o_busy(m_busy));
	two_wire_slave_address_ack two_wire_slave_address_ack_i (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .bus(two_wire_if_i.device), .i_connection_sense_input(sense),
		.i_addr_code(code), .i_rd_data(s_rd_data), .i_accept(accept), .o_wr_data(s_wr_data),
		.o_wr_valid(s_wr_valid), .o_rd_take(s_rd_take), .o_start(s_start), .o_stop(s_stop),
		.o_selected(s_selected), .o_rw(s_rw));
	two_wire_link_chk two_wire_link_chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.scl_m_out(two_wire_if_i.scl_m_out), .scl_m_oe(two_wire_if_i.scl_m_oe),
		.sda_m_out(two_wire_if_i.sda_m_out), .sda_m_oe(two_wire_if_i.sda_m_oe),
		.sda_s_out(two_wire_if_i.sda_s_out), .sda_s_oe(two_wire_if_i.sda_s_oe),
		.scl(scl_w), .sda(sda_w));

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp(got, exp, what);
	endtask : cmp_data

	task automatic cmp_flag(input logic got, input logic exp, input string what);
		cmp({7'h0, got}, {7'h0, exp}, what);
	endtask : cmp_flag

	task automatic cmp_count(input int got, input int exp, input string what);
		cmp(8'(got), 8'(exp), what);
	endtask : cmp_count

	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// Sources move on only after a take pulse, so each byte holds until loaded
	always @(posedge i_sys_clk) begin
		#2;
		m_wr_data = wdat[wi % 8];
		s_rd_data = rdat[ri % 8];
		accept = (wv < acc_n);
	end

	always @(negedge i_sys_clk) begin
		if (i_rst_n === 1'b1) begin
			if (s_wr_valid === 1'b1)
				cmp_data(s_wr_data, wr_q.size() ? wr_q.pop_front() : 8'hXX, "write");
			if (m_rd_valid === 1'b1)
				cmp_data(m_rd_data, rd_q.size() ? rd_q.pop_front() : 8'hXX, "read");
			if (m_done === 1'b1)
				cmp_flag(m_nack, done_q.pop_front(), "nack");
			wi += int'(m_wr_take === 1'b1);
			ri += int'(s_rd_take === 1'b1);
			wv += int'(s_wr_valid === 1'b1);
			st_n += int'(s_start === 1'b1);
			sp_n += int'(s_stop === 1'b1);
			sel_n += int'(s_selected === 1'b1);
			if (pscl && scl_w && psda && !sda_w) begin
				bit_n = 0;
				first = 1'b1;
			end
			if (!pscl && scl_w && first) begin
				sh = {sh[6:0], sda_w};
				bit_n++;
				if (bit_n == 8)
					cmp_data(sh, ab_exp, "address on wire");
				if (bit_n == 9)
					cmp_flag(sda_w, !ack_exp, "address ack");
				first = (bit_n < 9);
			end
		end
		pscl = scl_w;
		psda = sda_w;
	end

	task automatic run(input string name, input logic [6:0] a, input logic rw, input int len,
		input int acc, input logic ok);
		int k;
		repeat (5) @(posedge i_sys_clk);
		#2;
		for (k = 0; k < 8; k++) begin
			wdat[k] = 8'($urandom);
			rdat[k] = 8'($urandom);
		end
		for (k = 0; k < len; k++) begin
			if (ok && !rw && k < acc)
				wr_q.push_back(wdat[k]);
			if (ok && rw)
				rd_q.push_back(rdat[k]);
		end
		done_q.push_back(!ok || (!rw && acc < len));
		{wi, ri, wv, st_n, sp_n, sel_n} = '0;
		acc_n = acc;
		ab_exp = {a, rw};
		ack_exp = ok;
		go = 1'b1;
		m_addr = a;
		m_rw = rw;
		m_len = 8'(len);
		@(posedge i_sys_clk);
		#2;
		go = 1'b0;
		cmp_flag(m_busy, 1'b1, "busy");
		for (k = 0; k < 5000; k++) begin
			@(negedge i_sys_clk);
			if (m_done === 1'b1)
				break;
		end
		if (k == 5000)
			cmp_flag(1'b0, 1'b1, "no completion");
		repeat (10) @(posedge i_sys_clk);
		#2;
		cmp_count(st_n, int'(sense), "start count");
		cmp_count(sp_n, int'(sense), "stop count");
		cmp_flag(sel_n != 0, ok, "selected");
		cmp_count(wr_q.size() + rd_q.size(), 0, "leftover");
		cmp_flag(scl_w & sda_w, 1'b1, "idle lines");
		cmp_flag(m_busy, 1'b0, "busy after stop");
		if (ok)
			cmp_flag(s_rw, rw, "direction");
		$display("test %s ended", name);
	endtask : run

	initial begin
		repeat (60000) @(posedge i_sys_clk);
		cmp_flag(1'b0, 1'b1, "watchdog");
		conclude();
	end

	initial begin
		int b;
		{go, m_rw, m_addr, m_len, accept, m_wr_data, s_rd_data, acc_n} = '0;
		sense = 1'b1;
		void'($urandom(7));
		code = 5'($urandom);
		i_rst_n = 1'b0;
		repeat (10) @(posedge i_sys_clk);
		#2;
		i_rst_n = 1'b1;
		run("write", {2'h3, code}, 1'b0, 3, 8, 1'b1);
		run("addr_only", {2'h3, code}, 1'b0, 0, 8, 1'b1);
		run("refuse", {2'h3, code}, 1'b0, 3, 1, 1'b1);
		run("read", {2'h3, code}, 1'b1, 3, 8, 1'b1);
		run("read_one", {2'h3, code}, 1'b1, 1, 8, 1'b1);
		for (b = 0; b < 7; b++)
			run("wrong_addr", {2'h3, code} ^ (7'h1 << b), 1'b0, 1, 8, 1'b0);
		sense = 1'b0;
		run("sense_low", {2'h3, code}, 1'b0, 1, 8, 1'b0);
		sense = 1'b1;
		for (b = 0; b < 4; b++) begin
			code = 5'($urandom);
			run("code", {2'h3, code}, b[0], 2, 8, 1'b1);
		end
		conclude();
	end
endmodule : two_wire_slave_address_ack_bench

`default_nettype wire
